// ### verilog/timer_pkg.sv
// Purpose: Shared constants for the buffered compare timer.
// Assumes: AXI4-Lite register access, 32-bit data, one word per register.
// Notes: Offsets are byte addresses; all fields sit in the low bits.

// ****************************************************************
// Register map and field layout
// ****************************************************************
package timer_pkg;

	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] PERIOD_CMP_OFS = 8'h04;
	localparam logic [7:0] SECOND_CMP_OFS = 8'h08;
	localparam logic [7:0] OUT_CTRL_OFS = 8'h0C;
	localparam logic [7:0] EDGE_SEL_OFS = 8'h10;
	localparam logic [7:0] COUNT_OFS = 8'h14;
	localparam logic [7:0] INT_STATUS_OFS = 8'h18;
	localparam logic [7:0] INT_MASK_OFS = 8'h1C;
	localparam logic [7:0] PERIOD_BUF_OFS = 8'h20;
	localparam logic [7:0] SECOND_BUF_OFS = 8'h24;

	// Control register bit positions.
	localparam int RUN_BIT = 0;
	localparam int REWRITE_MODE_BIT = 1;
	localparam int PWM_MODE_BIT = 2;
	localparam int EVENT_COUNT_BIT = 3;
	localparam int ENCODER_MODE_BIT = 4;
	localparam int MATCH_CLEAR_LO_BIT = 5;
	localparam int MATCH_CLEAR_HI_BIT = 6;
	localparam int RELOAD_ENABLE_BIT = 7;
	localparam int ENC_CLEAR_ENABLE_BIT = 8;
	localparam int ENC_CLEAR_EDGE_LO_BIT = 9;
	localparam int ENC_CLEAR_EDGE_HI_BIT = 10;
	localparam logic [31:0] CTRL_MASK = 32'h0000_07FF;

	// Output control: enable at 2k, level/polarity at 2k+1.
	localparam logic [31:0] OUT_CTRL_MASK = 32'h0000_00FF;
	// Event edge field sits at bits 3:2; bits 1:0 and 7:4 read zero.
	localparam int EVENT_EDGE_LO_BIT = 2;
	localparam int EVENT_EDGE_HI_BIT = 3;
	localparam logic [31:0] EDGE_SEL_MASK = 32'h0000_000C;

	// Sticky status bits.
	localparam int ST_PERIOD_MATCH = 0;
	localparam int ST_SECOND_MATCH = 1;
	localparam int ST_UNDERFLOW = 2;
	localparam int ST_ENC_CLEAR = 3;
	localparam int STATUS_W = 4;

	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [15:0] CMP_RESET = 16'h0000;
	localparam logic [31:0] OUT_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] EDGE_SEL_RESET = 32'h0000_0000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Edge select codes shared by all three pin edge detectors.
	localparam logic [1:0] EDGE_NONE = 2'b00;
	localparam logic [1:0] EDGE_RISE = 2'b01;
	localparam logic [1:0] EDGE_FALL = 2'b10;
	localparam logic [1:0] EDGE_BOTH = 2'b11;

	// Byte-lane merge of a write into an existing word.
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
		input logic [31:0] new_val, input logic [3:0] strb);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

endpackage : timer_pkg

// ### verilog/pin_edge_detect.sv
// Purpose: Synchronise a pin and report its selected edge as a pulse.
// Assumes: Pin is asynchronous to aclk.
// Notes: Pulse is one cycle wide, two flops after the pin changes.
`timescale 1ns/1ps

module pin_edge_detect (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin,
	input wire logic [1:0] edge_sel,
	output logic level,
	output logic edge_pulse
);

	logic meta_reg;
	logic sync_reg;
	logic prev_reg;
	logic rise;
	logic fall;

	// ****************************************************************
	// Two-flop synchroniser and edge selection
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			meta_reg <= pin;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign rise = sync_reg & ~prev_reg;
	assign fall = ~sync_reg & prev_reg;
	assign level = sync_reg;
	assign edge_pulse = (edge_sel == timer_pkg::EDGE_RISE) ? rise :
		(edge_sel == timer_pkg::EDGE_FALL) ? fall :
		(edge_sel == timer_pkg::EDGE_BOTH) ? (rise | fall) : 1'b0;

endmodule : pin_edge_detect

// ### verilog/buffered_compare_timer.sv
// Purpose: 16-bit timer with batch-transferred compare buffers.
// Assumes: AXI4-Lite slave on aclk; pins are asynchronous.
// Notes: A write that collides with a transfer is software's fault.
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps

module buffered_compare_timer #(
	parameter int CNT_W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic event_count_input,
	input wire logic encoder_dir_input,
	input wire logic encoder_clear_input,
	output logic [3:0] timer_out,
	output logic irq
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	localparam int STATUS_W_L = timer_pkg::STATUS_W;

	logic awready_reg;
	logic wready_reg;
	logic aw_got_reg;
	logic w_got_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic arready_reg;
	logic rvalid_reg;
	logic [1:0] rresp_reg;
	logic [31:0] rdata_reg;

	logic [31:0] ctrl_reg;
	logic [CNT_W-1:0] period_cmp_reg;
	logic [CNT_W-1:0] second_cmp_reg;
	logic [31:0] out_ctrl_reg;
	logic [31:0] edge_sel_reg;
	logic [STATUS_W_L-1:0] status_reg;
	logic [STATUS_W_L-1:0] mask_reg;
	logic [CNT_W-1:0] period_buf_reg;
	logic [CNT_W-1:0] second_buf_reg;
	logic armed_reg;
	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	logic out0_toggle_reg;
	logic [3:0] timer_out_reg;
	logic irq_reg;

	// ****************************************************************
	// Bus write path
	// ****************************************************************
	wire aw_fire = awvalid & awready_reg;
	wire w_fire = wvalid & wready_reg;
	wire aw_have = aw_got_reg | aw_fire;
	wire w_have = w_got_reg | w_fire;
	wire do_write = aw_have & w_have & ~bvalid_reg;
	wire [7:0] wr_addr = aw_got_reg ? awaddr_reg : awaddr;
	wire [31:0] wr_data = w_got_reg ? wdata_reg : wdata;
	wire [3:0] wr_strb = w_got_reg ? wstrb_reg : wstrb;

	wire wr_ctrl = do_write & (wr_addr == timer_pkg::CTRL_OFS);
	wire wr_period = do_write & (wr_addr == timer_pkg::PERIOD_CMP_OFS);
	wire wr_second = do_write & (wr_addr == timer_pkg::SECOND_CMP_OFS);
	wire wr_out = do_write & (wr_addr == timer_pkg::OUT_CTRL_OFS);
	wire wr_edge = do_write & (wr_addr == timer_pkg::EDGE_SEL_OFS);
	wire wr_status = do_write & (wr_addr == timer_pkg::INT_STATUS_OFS);
	wire wr_mask = do_write & (wr_addr == timer_pkg::INT_MASK_OFS);
	wire wr_ro = (wr_addr == timer_pkg::COUNT_OFS) |
		(wr_addr == timer_pkg::PERIOD_BUF_OFS) |
		(wr_addr == timer_pkg::SECOND_BUF_OFS);
	wire wr_hit = wr_ctrl | wr_period | wr_second | wr_out | wr_edge |
		wr_status | wr_mask | (do_write & wr_ro);

	wire [31:0] period_wide = {{(32-CNT_W){1'b0}}, period_cmp_reg};
	wire [31:0] second_wide = {{(32-CNT_W){1'b0}}, second_cmp_reg};
	wire [31:0] period_merged = timer_pkg::merge_bytes(period_wide, wr_data,
		wr_strb);
	wire [31:0] second_merged = timer_pkg::merge_bytes(second_wide, wr_data,
		wr_strb);
	wire [31:0] w1c_bits = timer_pkg::merge_bytes(32'h0000_0000, wr_data,
		wr_strb);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= timer_pkg::RESP_OKAY;
		end else begin
			if (aw_fire) begin
				awready_reg <= 1'b0;
				awaddr_reg <= awaddr;
			end
			if (w_fire) begin
				wready_reg <= 1'b0;
				wdata_reg <= wdata;
				wstrb_reg <= wstrb;
			end
			aw_got_reg <= aw_have & ~do_write;
			w_got_reg <= w_have & ~do_write;
			if (do_write) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_hit ? timer_pkg::RESP_OKAY :
					timer_pkg::RESP_SLVERR;
			end else if (bvalid_reg & bready) begin
				bvalid_reg <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Bus read path
	// ****************************************************************
	wire ar_fire = arvalid & arready_reg;
	wire [31:0] count_wide = {{(32-CNT_W){1'b0}}, count_reg};
	wire [31:0] status_wide = {{(32-STATUS_W_L){1'b0}}, status_reg};
	wire [31:0] mask_wide = {{(32-STATUS_W_L){1'b0}}, mask_reg};
	wire [31:0] pbuf_wide = {{(32-CNT_W){1'b0}}, period_buf_reg};
	wire [31:0] sbuf_wide = {{(32-CNT_W){1'b0}}, second_buf_reg};
	wire rd_hit = (araddr == timer_pkg::CTRL_OFS) |
		(araddr == timer_pkg::PERIOD_CMP_OFS) |
		(araddr == timer_pkg::SECOND_CMP_OFS) |
		(araddr == timer_pkg::OUT_CTRL_OFS) |
		(araddr == timer_pkg::EDGE_SEL_OFS) |
		(araddr == timer_pkg::COUNT_OFS) |
		(araddr == timer_pkg::INT_STATUS_OFS) |
		(araddr == timer_pkg::INT_MASK_OFS) |
		(araddr == timer_pkg::PERIOD_BUF_OFS) |
		(araddr == timer_pkg::SECOND_BUF_OFS);
	wire [31:0] rd_mux =
		(araddr == timer_pkg::CTRL_OFS) ? ctrl_reg :
		(araddr == timer_pkg::PERIOD_CMP_OFS) ? period_wide :
		(araddr == timer_pkg::SECOND_CMP_OFS) ? second_wide :
		(araddr == timer_pkg::OUT_CTRL_OFS) ? out_ctrl_reg :
		(araddr == timer_pkg::EDGE_SEL_OFS) ? edge_sel_reg :
		(araddr == timer_pkg::COUNT_OFS) ? count_wide :
		(araddr == timer_pkg::INT_STATUS_OFS) ? status_wide :
		(araddr == timer_pkg::INT_MASK_OFS) ? mask_wide :
		(araddr == timer_pkg::PERIOD_BUF_OFS) ? pbuf_wide :
		(araddr == timer_pkg::SECOND_BUF_OFS) ? sbuf_wide : 32'h0000_0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rresp_reg <= timer_pkg::RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
		end else if (ar_fire) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_mux;
			rresp_reg <= rd_hit ? timer_pkg::RESP_OKAY :
				timer_pkg::RESP_SLVERR;
		end else if (rvalid_reg & rready) begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	// ****************************************************************
	// Pin inputs
	// ****************************************************************
	wire [1:0] event_edge = edge_sel_reg[timer_pkg::EVENT_EDGE_HI_BIT:
		timer_pkg::EVENT_EDGE_LO_BIT];
	wire [1:0] enc_edge = ctrl_reg[timer_pkg::ENC_CLEAR_EDGE_HI_BIT:
		timer_pkg::ENC_CLEAR_EDGE_LO_BIT];
	wire event_pulse;
	wire enc_clear_pulse;
	wire dir_level;

	pin_edge_detect event_det (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(event_count_input),
		.edge_sel(event_edge),
		.level(),
		.edge_pulse(event_pulse)
	);

	pin_edge_detect enc_clear_det (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(encoder_clear_input),
		.edge_sel(enc_edge),
		.level(),
		.edge_pulse(enc_clear_pulse)
	);

	pin_edge_detect dir_det (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(encoder_dir_input),
		.edge_sel(timer_pkg::EDGE_NONE),
		.level(dir_level),
		.edge_pulse()
	);

	// ****************************************************************
	// Counter and compare logic
	// ****************************************************************
	wire run = ctrl_reg[timer_pkg::RUN_BIT];
	wire anytime = ctrl_reg[timer_pkg::REWRITE_MODE_BIT];
	wire pwm = ctrl_reg[timer_pkg::PWM_MODE_BIT];
	wire ext_tick = ctrl_reg[timer_pkg::EVENT_COUNT_BIT];
	wire enc_mode = ctrl_reg[timer_pkg::ENCODER_MODE_BIT];
	wire clr_on0 = ctrl_reg[timer_pkg::MATCH_CLEAR_LO_BIT];
	wire clr_on1 = ctrl_reg[timer_pkg::MATCH_CLEAR_HI_BIT];
	wire reload_en = ctrl_reg[timer_pkg::RELOAD_ENABLE_BIT];
	wire enc_clr_en = ctrl_reg[timer_pkg::ENC_CLEAR_ENABLE_BIT];

	// External counting and encoder mode both step on the event edge.
	wire tick = run & ((ext_tick | enc_mode) ? event_pulse : 1'b1);
	wire down = enc_mode & dir_level;
	wire hit0 = tick & (count_reg == period_buf_reg);
	wire hit1 = tick & (count_reg == second_buf_reg);
	wire underflow = tick & down & (count_reg == '0);
	// Select 00 leaves both matches without effect on the count, except the PWM-mode period match.
	wire match_clear = (clr_on0 & hit0) | (clr_on1 & hit1);
	wire enc_clear = run & enc_clr_en & enc_clear_pulse;
	wire pwm_clear = pwm & hit0 & ~down;
	wire counter_clear = match_clear | enc_clear | pwm_clear;
	// PWM transfers on the clear, other modes on the period match.
	wire transfer_time = pwm ? counter_clear : hit0;
	wire do_transfer = run & ~anytime & armed_reg & transfer_time;
	// The period event shares the transfer cycle so software may rewrite.
	wire period_event = hit0 | do_transfer;

	always_comb begin
		count_next = count_reg;
		if (counter_clear) begin
			count_next = '0;
		end else if (underflow) begin
			count_next = reload_en ? period_cmp_reg : '1;
		end else if (tick & down) begin
			count_next = count_reg - 1'b1;
		end else if (tick) begin
			count_next = count_reg + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_reg <= timer_pkg::COUNT_RESET;
		end else begin
			count_reg <= count_next;
		end
	end

	// ****************************************************************
	// Software registers and compare buffers
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= timer_pkg::CTRL_RESET;
			period_cmp_reg <= timer_pkg::CMP_RESET;
			second_cmp_reg <= timer_pkg::CMP_RESET;
			out_ctrl_reg <= timer_pkg::OUT_CTRL_RESET;
			edge_sel_reg <= timer_pkg::EDGE_SEL_RESET;
			mask_reg <= '0;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= timer_pkg::merge_bytes(ctrl_reg, wr_data,
					wr_strb) & timer_pkg::CTRL_MASK;
			end
			if (wr_period) begin
				period_cmp_reg <= period_merged[CNT_W-1:0];
			end
			if (wr_second) begin
				second_cmp_reg <= second_merged[CNT_W-1:0];
			end
			if (wr_out) begin
				out_ctrl_reg <= timer_pkg::merge_bytes(out_ctrl_reg, wr_data,
					wr_strb) & timer_pkg::OUT_CTRL_MASK;
			end
			if (wr_edge) begin
				edge_sel_reg <= timer_pkg::merge_bytes(edge_sel_reg, wr_data,
					wr_strb) & timer_pkg::EDGE_SEL_MASK;
			end
			if (wr_mask) begin
				mask_reg <= wr_data[STATUS_W_L-1:0];
			end
		end
	end

	// A second-compare write in the transfer cycle keeps the arm set.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			period_buf_reg <= timer_pkg::CMP_RESET;
			second_buf_reg <= timer_pkg::CMP_RESET;
			armed_reg <= 1'b0;
		end else begin
			if (anytime) begin
				if (wr_period) begin
					period_buf_reg <= period_merged[CNT_W-1:0];
				end
				if (wr_second) begin
					second_buf_reg <= second_merged[CNT_W-1:0];
				end
			end else if (do_transfer) begin
				period_buf_reg <= period_cmp_reg;
				second_buf_reg <= second_cmp_reg;
			end
			armed_reg <= wr_second | (armed_reg & ~do_transfer);
		end
	end

	// ****************************************************************
	// Interrupt status
	// ****************************************************************
	wire [STATUS_W_L-1:0] events = {enc_clear, underflow, hit1, period_event};
	wire [STATUS_W_L-1:0] clr_bits = wr_status ? w1c_bits[STATUS_W_L-1:0] :
		'0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			status_reg <= events | (status_reg & ~clr_bits);
			irq_reg <= |((events | (status_reg & ~clr_bits)) & mask_reg);
		end
	end

	// ****************************************************************
	// Timer output pins
	// ****************************************************************
	// Outputs 1-3 share the second buffer as their duty threshold.
	wire width_active = count_reg < second_buf_reg;
	logic [3:0] out_next;

	always_comb begin
		out_next[0] = out_ctrl_reg[0] ? out0_toggle_reg :
			out_ctrl_reg[1];
		for (int k = 1; k < 4; k++) begin
			// A disabled output rests at its inactive level.
			out_next[k] = (out_ctrl_reg[2*k] & width_active) ^
				out_ctrl_reg[2*k+1];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out0_toggle_reg <= 1'b0;
			timer_out_reg <= 4'h0;
		end else begin
			if (!out_ctrl_reg[0]) begin
				out0_toggle_reg <= out_ctrl_reg[1];
			end else if (hit0) begin
				out0_toggle_reg <= ~out0_toggle_reg;
			end
			timer_out_reg <= out_next;
		end
	end

	assign awready = awready_reg;
	assign wready = wready_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign arready = arready_reg;
	assign rvalid = rvalid_reg;
	assign rresp = rresp_reg;
	assign rdata = rdata_reg;
	assign timer_out = timer_out_reg;
	assign irq = irq_reg;

endmodule : buffered_compare_timer

// ### tb/timer_monitor.sv
// Purpose: Bus protocol checks and an interrupt cover for the compare timer.
// Assumes: Sees only the top module's ports.
// Notes: Bound into every instance of the timer.
`timescale 1ns/1ps

module timer_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic irq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ****************************************************************
	// Handshake checks
	// ****************************************************************
	chk_b_after_both: assert property (awvalid && awready && wvalid &&
		wready |=> bvalid) else $error("write answer missing");
	chk_b_holds: assert property (bvalid && !bready |=> bvalid &&
		$stable(bresp)) else $error("write answer not held");
	chk_b_release: assert property (bvalid && bready |=> !bvalid &&
		awready && wready) else $error("write channel not reopened");
	chk_w_busy: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while answer pending");
	chk_r_after_ar: assert property (arvalid && arready |=> rvalid &&
		!arready) else $error("read answer missing");
	chk_r_holds: assert property (rvalid && !rready |=> rvalid &&
		$stable(rdata) && $stable(rresp)) else $error("read not held");
	chk_r_release: assert property (rvalid && rready |=> !rvalid &&
		arready) else $error("read channel not reopened");
	chk_err_zero: assert property (rvalid && rresp == 2'h2 |->
		rdata == 32'h0000_0000) else $error("error read not zero");

	cover property (bvalid && bready && bresp == 2'h2);
	cover property (rvalid && rready && rresp == 2'h2);
	cover property ($rose(irq));
endmodule : timer_monitor

bind buffered_compare_timer timer_monitor i_timer_monitor (
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready),
	.bresp(bresp), .bvalid(bvalid), .bready(bready),
	.arvalid(arvalid), .arready(arready), .rdata(rdata),
	.rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq)
);

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the buffered compare timer.
// Assumes: AXI4-Lite master tasks drive on the rising edge.
// Notes: Fixed waits only let the timer run; bus waits are open.
`timescale 1ns/1ps

module tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic enc_clr = 1'b0;
	logic ev_in = 1'b0;
	logic dir_in = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp, last_resp;
	logic [31:0] rdata, v;
	logic [3:0] timer_out;
	int err_total = 0;
	int n_checks = 0;
	int hi_a, hi_b;

	always #2 aclk = ~aclk;

	buffered_compare_timer i_buffered_compare_timer (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .event_count_input(ev_in),
		.encoder_dir_input(dir_in), .encoder_clear_input(enc_clr),
		.timer_out(timer_out), .irq(irq)
	);

	// ****************************************************************
	// Bus and compare helpers
	// ****************************************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		last_resp = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		last_resp = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		check(d, exp);
	endtask : rc

	task automatic idle(input int n);
		repeat (n) @(posedge aclk);
	endtask : idle

	// Counts high cycles of output one over a whole number of periods.
	task automatic count_hi(output int hi);
		hi = 0;
		repeat (272) begin
			@(posedge aclk);
			if (timer_out[1] === 1'b1) hi++;
		end
	endtask : count_hi

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_regs;
		rc(timer_pkg::CTRL_OFS, timer_pkg::CTRL_RESET);
		rc(timer_pkg::OUT_CTRL_OFS, timer_pkg::OUT_CTRL_RESET);
		rc(timer_pkg::EDGE_SEL_OFS, timer_pkg::EDGE_SEL_RESET);
		rc(timer_pkg::INT_STATUS_OFS, 32'h0000_0000);
		wr(timer_pkg::EDGE_SEL_OFS, 32'hFFFF_FFFF);
		rc(timer_pkg::EDGE_SEL_OFS, 32'h0000_000C);
		rd(8'h30, v);
		check(v, 32'h0000_0000);
		check({30'h0, last_resp}, {30'h0, timer_pkg::RESP_SLVERR});
		wr(8'h30, 32'h0000_1234);
		check({30'h0, last_resp}, {30'h0, timer_pkg::RESP_SLVERR});
	endtask : t_regs

	task automatic t_batch;
		wr(timer_pkg::PERIOD_CMP_OFS, 32'h0000_0014);
		wr(timer_pkg::SECOND_CMP_OFS, 32'h0000_0005);
		wr(timer_pkg::CTRL_OFS, 32'h0000_0021);
		idle(10);
		rc(timer_pkg::PERIOD_BUF_OFS, 32'h0000_0014);
		rc(timer_pkg::SECOND_BUF_OFS, 32'h0000_0005);
		wr(timer_pkg::PERIOD_CMP_OFS, 32'h0000_001E);
		idle(60);
		rc(timer_pkg::PERIOD_BUF_OFS, 32'h0000_0014);
		wr(timer_pkg::SECOND_CMP_OFS, 32'h0000_0005);
		idle(60);
		rc(timer_pkg::PERIOD_BUF_OFS, 32'h0000_001E);
		wr(timer_pkg::INT_MASK_OFS, 32'h0000_0001);
		idle(2);
		check({31'h0, irq}, 32'h0000_0001);
		wr(timer_pkg::INT_MASK_OFS, 32'h0000_0000);
		idle(2);
		check({31'h0, irq}, 32'h0000_0000);
	endtask : t_batch

	task automatic t_pwm;
		wr(timer_pkg::CTRL_OFS, 32'h0000_0005);
		wr(timer_pkg::PERIOD_CMP_OFS, 32'h0000_0010);
		wr(timer_pkg::SECOND_CMP_OFS, 32'h0000_0008);
		idle(80);
		rc(timer_pkg::PERIOD_BUF_OFS, 32'h0000_0010);
		rc(timer_pkg::SECOND_BUF_OFS, 32'h0000_0008);
		wr(timer_pkg::OUT_CTRL_OFS, 32'h0000_0004);
		idle(3);
		count_hi(hi_a);
		wr(timer_pkg::OUT_CTRL_OFS, 32'h0000_000C);
		idle(3);
		count_hi(hi_b);
		check(hi_a + hi_b, 32'd272);
		check({31'h0, hi_a != 0}, 32'h0000_0001);
		check(hi_a, 32'd128);
		wr(timer_pkg::SECOND_CMP_OFS, 32'h0000_0004);
		idle(80);
		rc(timer_pkg::SECOND_BUF_OFS, 32'h0000_0004);
		rc(timer_pkg::PERIOD_BUF_OFS, 32'h0000_0010);
		wr(timer_pkg::OUT_CTRL_OFS, 32'h0000_00AA);
		idle(3);
		check({28'h0, timer_out}, 32'h0000_000F);
		wr(timer_pkg::OUT_CTRL_OFS, 32'h0000_0000);
		idle(3);
		check({28'h0, timer_out}, 32'h0000_0000);
	endtask : t_pwm

	task automatic t_anytime;
		wr(timer_pkg::CTRL_OFS, 32'h0000_0003);
		wr(timer_pkg::PERIOD_CMP_OFS, 32'h0000_000A);
		rc(timer_pkg::PERIOD_BUF_OFS, 32'h0000_000A);
		repeat (20) begin
			idle(5);
			enc_clr <= ~enc_clr;
		end
		rd(timer_pkg::COUNT_OFS, v);
		check({31'h0, v > 32'h0000_000A}, 32'h0000_0001);
		rd(timer_pkg::INT_STATUS_OFS, v);
		check({31'h0, v[3]}, 32'h0000_0000);
		wr(timer_pkg::CTRL_OFS, 32'h0000_0000);
		wr(timer_pkg::INT_MASK_OFS, 32'h0000_0001);
		wr(timer_pkg::INT_STATUS_OFS, 32'h0000_000F);
		rc(timer_pkg::INT_STATUS_OFS, 32'h0000_0000);
		check({31'h0, irq}, 32'h0000_0000);
	endtask : t_anytime

	// Encoder mode with the direction pin high counts event edges down; the clear pin zeroes the count first, so one edge underflows.
	task automatic t_encoder;
		dir_in <= 1'b1;
		wr(timer_pkg::EDGE_SEL_OFS, 32'h0000_0004);
		wr(timer_pkg::CTRL_OFS, 32'h0000_0311);
		enc_clr <= 1'b1;
		idle(6);
		rc(timer_pkg::COUNT_OFS, 32'h0000_0000);
		ev_in <= 1'b1;
		idle(6);
		rc(timer_pkg::COUNT_OFS, 32'h0000_FFFF);
		rd(timer_pkg::INT_STATUS_OFS, v);
		check({31'h0, v[2]}, 32'h0000_0001);
		ev_in <= 1'b0;
		idle(6);
		rc(timer_pkg::COUNT_OFS, 32'h0000_FFFF);
		wr(timer_pkg::CTRL_OFS, 32'h0000_0391);
		enc_clr <= 1'b0;
		idle(6);
		enc_clr <= 1'b1;
		idle(6);
		ev_in <= 1'b1;
		idle(6);
		rc(timer_pkg::COUNT_OFS, 32'h0000_000A);
	endtask : t_encoder

	task automatic final_report;
		$display("Checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_batch();
		t_pwm();
		t_anytime();
		t_encoder();
		final_report();
	end

	// The whole run needs about 1100 cycles; this allows over fifteen times.
	initial begin
		#80000;
		err_total++;
		final_report();
	end
endmodule : tb_top
